/* File: aos_pkg.sv */
// Package for the analog output sequencer: command codes, register layout, limits.
// Assumes a single 125 MHz clock domain and a plain strobe register port.
package aos_pkg;

    // Register offsets (word index on the plain port)
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_CMD      = 4'h1;
    localparam logic [3:0] REG_STATUS   = 4'h2;
    localparam logic [3:0] REG_DATA     = 4'h3;
    localparam logic [3:0] REG_CLKDIV   = 4'h4;
    localparam logic [3:0] REG_CHCNT    = 4'h5;
    localparam logic [3:0] REG_SMPCNT   = 4'h6;
    localparam logic [3:0] REG_REPEAT   = 4'h7;
    localparam logic [3:0] REG_OUTCNT   = 4'h8;
    localparam logic [3:0] REG_XFERLVL  = 4'h9;
    localparam logic [3:0] REG_FILL     = 4'hA;
    localparam logic [3:0] REG_DONECNT  = 4'hB;

    // Control field positions
    localparam int CTRL_RING     = 0;
    localparam int CTRL_EXTCLK   = 1;
    localparam int CTRL_STARTEXT = 2;
    localparam int CTRL_STARTFALL= 3;
    localparam int CTRL_STOP_LO  = 4;
    localparam int CTRL_STOPFALL = 6;
    localparam int CTRL_CLKFALL  = 7;

    // Command bits
    localparam int CMD_START     = 0;
    localparam int CMD_STOP      = 1;
    localparam int CMD_STATRST   = 2;
    localparam int CMD_MEMRST    = 3;

    // Status bit positions
    localparam int ST_RUN        = 0;
    localparam int ST_WAITTRIG   = 1;
    localparam int ST_OUTDONE    = 2;
    localparam int ST_CLKERR     = 3;
    localparam int ST_OVFERR     = 4;
    localparam int ST_STARTEV    = 5;
    localparam int ST_REPEV      = 6;
    localparam int ST_ENDEV      = 7;
    localparam int ST_XFEREV     = 8;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [15:0] CODE_ZERO    = 16'h8000; // Midscale code, 0 V
    localparam logic [31:0] REPEAT_FOREVER = 32'h0000_0000;

    // Converter load time per channel; shorter periods flag a clock error
    localparam int CONV_NS       = 80;
    localparam int CLK_NS        = 8;
    localparam int CONV_CYCLES   = (CONV_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        STOP_COUNT = 2'b00,
        STOP_EXT   = 2'b01,
        STOP_SW    = 2'b10
    } aos_stop_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_WAIT  = 3'b001,
        S_RUN   = 3'b010,
        S_CONV  = 3'b011,
        S_ARM   = 3'b100
    } aos_state_t;

    // Sample handed to the converters
    typedef struct packed {
        logic        load;
        logic [3:0]  chan;
        logic [15:0] code;
    } aos_dac_t;

endpackage

/* File: aos_mem.sv */
// Sample memory for the sequencer: one write port, one registered read port.
// Assumes the caller keeps addresses in range.
`timescale 1ns/1ns
module aos_mem import aos_pkg::*; #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    // Clock
    input  wire logic          sys_clk,
    // Write side
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrAddr,
    input  wire logic [DW-1:0] wrData,
    // Read side
    input  wire logic [AW-1:0] rdAddr,
    output logic      [DW-1:0] rdData
);
    logic [DW-1:0] store [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    // Read data always from a register
    always_ff @(posedge sys_clk) begin
        rdData <= store[rdAddr];
    end
endmodule // aos_mem

/* File: aos_edge.sv */
// Pin input conditioner: two-flop synchroniser plus rising/falling detector.
// Assumes an asynchronous pin; the selected edge comes out as one pulse.
`timescale 1ns/1ns
module aos_edge import aos_pkg::*; (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Pin and edge choice
    input  wire logic pin,
    input  wire logic fallSel,
    // Detected edge
    output logic      edgePulse
);
    logic sync1;
    logic sync2;
    logic last;

    // Synchroniser; first stage feeds only the second
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            last  <= 1'b0;
        end else begin
            sync1 <= pin;
            sync2 <= sync1;
            last  <= sync2;
        end
    end

    assign edgePulse = fallSel ? (last & ~sync2) : (~last & sync2);
endmodule // aos_edge

/* File: analog_output_sequencer.sv */
// Analog output sequencer: sample buffer, sampling clock, start/stop control, events.
// Assumes a host on a plain strobe register port and converters taking one code per load.
`timescale 1ns/1ns
module analog_output_sequencer import aos_pkg::*; #(
    parameter int AW    = 12,
    parameter int NCH   = 16
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    // External pins
    input  wire logic        ext_start_trigger_in,
    input  wire logic        ext_stop_trigger_in,
    input  wire logic        ext_sample_clock_in,
    // Converter side
    output aos_dac_t         dacOut
);
    localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

    aos_state_t state;
    logic [31:0] ctrl;
    logic [31:0] clkDiv;
    logic [4:0]  chCount;
    logic [31:0] smpTarget;
    logic [31:0] repTarget;
    logic [31:0] outTarget;
    logic [AW:0] xferLevel;
    logic [8:0]  status;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   fill;
    logic [31:0] divCnt;
    logic [31:0] periodCnt;
    logic [31:0] repCnt;
    logic [31:0] outCnt;
    logic [4:0]  chIdx;
    logic [7:0]  convCnt;
    logic [15:0] memRd;
    logic        rdPend;
    logic [3:0]  pendChan;
    logic        startEdge;
    logic        stopEdge;
    logic        clkEdge;
    logic        tick;
    logic        dataWr;
    logic        memWr;
    logic        popNow;
    logic        cmdStart;
    logic        cmdStop;
    logic        cmdStatRst;
    logic        cmdMemRst;
    logic        errNow;
    logic        periodDone;
    logic        ringEnd;
    logic        stopCnt;
    aos_stop_t   stopSel;

    // Trigger and clock pins, each synchronised before use
    aos_edge uStart (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ext_start_trigger_in),
                     .fallSel(ctrl[CTRL_STARTFALL]), .edgePulse(startEdge));
    aos_edge uStop  (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ext_stop_trigger_in),
                     .fallSel(ctrl[CTRL_STOPFALL]), .edgePulse(stopEdge));
    aos_edge uClk   (.sys_clk(sys_clk), .rst_n(rst_n), .pin(ext_sample_clock_in),
                     .fallSel(ctrl[CTRL_CLKFALL]), .edgePulse(clkEdge));

    // Command decode
    assign cmdStart   = regWr && regAddr == REG_CMD && regWrData[CMD_START];
    assign cmdStop    = regWr && regAddr == REG_CMD && regWrData[CMD_STOP];
    assign cmdStatRst = regWr && regAddr == REG_CMD && regWrData[CMD_STATRST];
    assign cmdMemRst  = regWr && regAddr == REG_CMD && regWrData[CMD_MEMRST];
    assign dataWr     = regWr && regAddr == REG_DATA;
    assign stopSel    = aos_stop_t'(ctrl[CTRL_STOP_LO +: 2]);

    // Ring loads blocked while running; FIFO loads always allowed unless full
    assign memWr = dataWr && fill != DEPTH &&
                   !(ctrl[CTRL_RING] && state != S_IDLE);

    // Sample tick from internal divider or external clock edge
    assign tick = ctrl[CTRL_EXTCLK] ? clkEdge : (divCnt == 32'h0);

    // A tick while channels are still loading means the period is too short
    assign errNow = tick && (state == S_CONV);

    assign popNow = state == S_CONV && convCnt == 8'h0;
    assign periodDone = popNow && chIdx == chCount - 5'h1;
    assign ringEnd = ctrl[CTRL_RING] && rdPtr == wrPtr - 1'b1 && popNow;
    assign stopCnt = periodCnt + 32'h1 >= smpTarget;

    // Internal sampling divider
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt <= 32'h0;
        end else if (state == S_IDLE || state == S_WAIT || divCnt == 32'h0) begin
            divCnt <= clkDiv;
        end else begin
            divCnt <= divCnt - 32'h1;
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl      <= CTRL_RESET;
            clkDiv    <= 32'h0000_00FF;
            chCount   <= 5'h01;
            smpTarget <= 32'h0000_0001;
            repTarget <= REPEAT_FOREVER;
            outTarget <= 32'h0;
            xferLevel <= '0;
        end else if (regWr) begin
            case (regAddr)
                REG_CTRL:    ctrl      <= regWrData;
                REG_CLKDIV:  clkDiv    <= regWrData;
                REG_CHCNT:   chCount   <= (regWrData[4:0] == 5'h0) ? 5'h01 :
                                          (regWrData[4:0] > 5'(NCH)) ? 5'(NCH) : regWrData[4:0];
                REG_SMPCNT:  smpTarget <= regWrData;
                REG_REPEAT:  repTarget <= regWrData;
                REG_OUTCNT:  outTarget <= regWrData;
                REG_XFERLVL: xferLevel <= regWrData[AW:0];
                default: ;
            endcase
        end
    end

    // Buffer pointers and fill level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill  <= '0;
        end else if (cmdMemRst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            fill  <= '0;
        end else begin
            if (memWr) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (state == S_IDLE && ctrl[CTRL_RING] && cmdStart) begin
                rdPtr <= '0;
            end else if (popNow && ctrl[CTRL_RING]) begin
                rdPtr <= ringEnd ? '0 : rdPtr + 1'b1;
            end else if (popNow && fill != '0) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (!ctrl[CTRL_RING]) begin
                fill <= fill + (AW+1)'(memWr) - (AW+1)'(popNow && fill != '0);
            end else begin
                fill <= fill + (AW+1)'(memWr);
            end
        end
    end

    aos_mem #(.AW(AW), .DW(16)) uMem (
        .sys_clk (sys_clk),
        .wrEn    (memWr),
        .wrAddr  (wrPtr),
        .wrData  (regWrData[15:0]),
        .rdAddr  (rdPtr),
        .rdData  (memRd)
    );

    // Sequencer: idle, trigger wait, period wait, channel loading, stop arm
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= S_IDLE;
            periodCnt <= 32'h0;
            repCnt    <= 32'h0;
            chIdx     <= 5'h0;
            convCnt   <= 8'h0;
        end else if (cmdStop || errNow) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: if (cmdStart) begin
                    periodCnt <= 32'h0;
                    repCnt    <= 32'h0;
                    state <= ctrl[CTRL_STARTEXT] ? S_WAIT : S_RUN;
                end
                S_WAIT: if (startEdge) begin
                    state <= S_RUN;
                end
                S_RUN: if (tick) begin
                    chIdx   <= 5'h0;
                    convCnt <= 8'(CONV_CYCLES);
                    state   <= S_CONV;
                end
                S_CONV: if (convCnt != 8'h0) begin
                    convCnt <= convCnt - 8'h1;
                end else if (!periodDone) begin
                    chIdx   <= chIdx + 5'h1;
                    convCnt <= 8'(CONV_CYCLES);
                end else begin
                    periodCnt <= periodCnt + 32'h1;
                    if (ctrl[CTRL_RING] && ringEnd) begin
                        repCnt <= repCnt + 32'h1;
                        if (repTarget != REPEAT_FOREVER && repCnt + 32'h1 >= repTarget) begin
                            state <= S_IDLE;
                        end else begin
                            state <= ctrl[CTRL_STARTEXT] ? S_WAIT : S_RUN;
                        end
                    end else if (stopSel == STOP_COUNT && stopCnt) begin
                        state <= S_IDLE;
                    end else if (stopSel == STOP_EXT && stopCnt) begin
                        state <= S_ARM;
                    end else begin
                        state <= S_RUN;
                    end
                end
                S_ARM: if (stopEdge) begin
                    state <= S_IDLE;
                end else if (tick) begin
                    chIdx   <= 5'h0;
                    convCnt <= 8'(CONV_CYCLES);
                    state   <= S_CONV;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Count of channel pops, including pops from an empty FIFO that load nothing
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            outCnt <= 32'h0;
        end else if (state == S_IDLE && cmdStart) begin
            outCnt <= 32'h0;
        end else if (popNow) begin
            outCnt <= outCnt + 32'h1;
        end
    end

    // Converter load: memory read lands one cycle after the pop
    // Channel is held back with the code so both move only on a load
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdPend   <= 1'b0;
            pendChan <= 4'h0;
            dacOut   <= '{load: 1'b0, chan: 4'h0, code: CODE_ZERO};
        end else begin
            rdPend      <= popNow && (ctrl[CTRL_RING] || fill != '0);
            dacOut.load <= 1'b0;
            if (popNow) begin
                pendChan <= chIdx[3:0];
            end
            if (rdPend) begin
                dacOut.load <= 1'b1;
                dacOut.chan <= pendChan;
                dacOut.code <= memRd;
            end
        end
    end

    // Status flags: hardware set wins over software clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= '0;
        end else begin
            status[ST_RUN]      <= state != S_IDLE || cmdStart;
            if (cmdStop || errNow) begin
                status[ST_RUN]  <= 1'b0;
            end
            status[ST_WAITTRIG] <= (state == S_WAIT && !startEdge) ||
                                   (state == S_IDLE && cmdStart && ctrl[CTRL_STARTEXT]);
            if (cmdStatRst) begin
                status[ST_CLKERR]  <= 1'b0;
                status[ST_OVFERR]  <= 1'b0;
                status[ST_STARTEV] <= 1'b0;
                status[ST_REPEV]   <= 1'b0;
                status[ST_ENDEV]   <= 1'b0;
                status[ST_XFEREV]  <= 1'b0;
            end
            if (cmdMemRst || (state == S_IDLE && cmdStart)) begin
                status[ST_OUTDONE] <= 1'b0;
            end
            if (errNow) begin
                status[ST_CLKERR] <= 1'b1;
            end
            if (dataWr && !memWr && !ctrl[CTRL_RING]) begin
                status[ST_OVFERR] <= 1'b1;
            end
            if (state == S_WAIT && startEdge) begin
                status[ST_STARTEV] <= 1'b1;
            end
            if (periodDone && ringEnd) begin
                status[ST_REPEV] <= 1'b1;
            end
            if (state == S_CONV && periodDone && state != S_IDLE &&
                ((ringEnd && repTarget != REPEAT_FOREVER && repCnt + 32'h1 >= repTarget) ||
                 (!ctrl[CTRL_RING] && stopSel == STOP_COUNT && stopCnt))) begin
                status[ST_ENDEV] <= 1'b1;
            end
            if (state == S_ARM && stopEdge) begin
                status[ST_ENDEV] <= 1'b1;
            end
            if (popNow && outCnt + 32'h1 == outTarget) begin
                status[ST_OUTDONE] <= 1'b1;
            end
            if ((!ctrl[CTRL_RING] && state != S_IDLE && fill < xferLevel) ||
                (ctrl[CTRL_RING] && popNow && outCnt + 32'h1 == outTarget)) begin
                status[ST_XFEREV] <= 1'b1;
            end
        end
    end

    // Register read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 32'h0;
        end else if (regRd) begin
            case (regAddr)
                REG_CTRL:    regRdData <= ctrl;
                REG_STATUS:  regRdData <= {23'h0, status};
                REG_CLKDIV:  regRdData <= clkDiv;
                REG_CHCNT:   regRdData <= {27'h0, chCount};
                REG_SMPCNT:  regRdData <= smpTarget;
                REG_REPEAT:  regRdData <= repTarget;
                REG_OUTCNT:  regRdData <= outTarget;
                REG_XFERLVL: regRdData <= 32'(xferLevel);
                REG_FILL:    regRdData <= 32'(fill);
                REG_DONECNT: regRdData <= outCnt;
                default:     regRdData <= 32'h0;
            endcase
        end else begin
            regRdData <= 32'h0;
        end
    end
endmodule // analog_output_sequencer

/* File: aos_dac_model.sv */
// Converter channel model: logs every code load as {chan, code}.
// Assumes loads are one-cycle pulses on the sequencer clock.
`timescale 1ns/1ns
module aos_dac_model import aos_pkg::*; (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Converter feed
    input  aos_dac_t  dacOut
);
    logic [19:0] seen [$];
    // A channel only takes its code on a load; idle cycles are ignored
    always @(posedge sys_clk) begin
        if (rst_n && dacOut.load === 1'h1) begin
            seen.push_back({dacOut.chan, dacOut.code});
        end
    end
endmodule // aos_dac_model

/* File: aos_seq_sva.sv */
// Port checker for the analog output sequencer, bound to its top module.
// Assumes one clock domain and the register map of aos_pkg.
`timescale 1ns/1ns
module aos_seq_sva import aos_pkg::*; #(
    parameter int AW  = 12,
    parameter int NCH = 16
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    // Pins and converter feed
    input wire logic        ext_start_trigger_in,
    input wire logic        ext_stop_trigger_in,
    input wire logic        ext_sample_clock_in,
    input aos_dac_t         dacOut
);
    logic [4:0] chCnt;
    logic       startExt;
    logic       waitArm;
    logic       extSeen;
    wire        cmdWr = regWr && regAddr == REG_CMD;
    wire        goExt = cmdWr && regWrData[CMD_START] && startExt;
    wire        stRd  = regRd && regAddr == REG_STATUS;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Shadow of the setup the host wrote
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chCnt    <= 5'h00;
            startExt <= 1'h0;
        end else if (regWr && regAddr == REG_CHCNT) begin
            chCnt <= regWrData[4:0];
        end else if (regWr && regAddr == REG_CTRL) begin
            startExt <= regWrData[CTRL_STARTEXT];
        end
    end
    // Armed until the pin moves or a stop command is written; sync plus load latency keeps this safe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            waitArm <= 1'h0;
            extSeen <= 1'h0;
        end else begin
            waitArm <= goExt || (waitArm && !$changed(ext_start_trigger_in) && !(cmdWr && regWrData[CMD_STOP]));
            extSeen <= goExt || (extSeen && !(cmdWr && regWrData[CMD_STATRST]));
        end
    end
    a_load_gap: assert property (dacOut.load |=> !dacOut.load [*8])
        else $error("converter loads closer than the load time");
    a_chan_range: assert property (dacOut.load |-> {1'h0, dacOut.chan} < chCnt)
        else $error("channel beyond configured count");
    a_code_hold: assert property (!dacOut.load |-> $stable(dacOut.code) && $stable(dacOut.chan))
        else $error("converter code moved without a load");
    a_reset_mid: assert property ($rose(rst_n) |-> dacOut.code == CODE_ZERO && !dacOut.load)
        else $error("code not midscale after reset");
    a_ext_wait: assert property (waitArm |-> !dacOut.load)
        else $error("load before the start trigger");
    a_err_halt: assert property (stRd ##1 regRdData[ST_CLKERR] |-> !dacOut.load [*8])
        else $error("loads continue after a clock error");
    a_wait_run: assert property (stRd ##1 regRdData[ST_WAITTRIG] |-> regRdData[ST_RUN])
        else $error("waiting for trigger while not operating");
    a_start_ev: assert property (stRd ##1 regRdData[ST_STARTEV] |-> extSeen)
        else $error("start event without an external start");
    c_last_chan: cover property (dacOut.load && {1'h0, dacOut.chan} == chCnt - 5'h01);
    c_ext_go: cover property ($fell(waitArm));
    c_clk_err: cover property (stRd ##1 regRdData[ST_CLKERR]);
endmodule // aos_seq_sva
bind analog_output_sequencer aos_seq_sva #(.AW(AW), .NCH(NCH)) u_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .ext_start_trigger_in(ext_start_trigger_in),
    .ext_stop_trigger_in(ext_stop_trigger_in), .ext_sample_clock_in(ext_sample_clock_in), .dacOut(dacOut));

/* File: analog_output_sequencer_tb.sv */
// Self-checking bench for the analog output sequencer with a converter model.
// Assumes the package register map; AW is cut to 4 so the FIFO fills fast.
`timescale 1ns/1ns
module analog_output_sequencer_tb import aos_pkg::*;;
    localparam int AW = 4;
    logic        sys_clk              = 1'h0;
    logic        rst_n                = 1'h0;
    logic [3:0]  regAddr              = 4'h0;
    logic [31:0] regWrData            = 32'h0;
    logic        regWr                = 1'h0;
    logic        regRd                = 1'h0;
    logic        ext_start_trigger_in = 1'h0;
    logic        ext_stop_trigger_in  = 1'h0;
    logic        ext_sample_clock_in  = 1'h0;
    logic [31:0] regRdData;
    aos_dac_t    dacOut;
    logic [15:0] exp [$];
    logic [31:0] d;
    int          n_errors   = 0;
    int          num_checks = 0;
    analog_output_sequencer #(.AW(AW), .NCH(16)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .ext_start_trigger_in(ext_start_trigger_in),
        .ext_stop_trigger_in(ext_stop_trigger_in), .ext_sample_clock_in(ext_sample_clock_in), .dacOut(dacOut));
    aos_dac_model dac (.sys_clk(sys_clk), .rst_n(rst_n), .dacOut(dacOut));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] expLoad(input int i, input int chn);
        return {12'h0, 4'(i % chn), exp[i]};
    endfunction
    task automatic conclude();
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            n_errors++;
            $display("ERROR %0t: got %h, expected %h", $time, got, want);
        end
    endtask
    // Bus cycles: strobes stand one cycle, read data sampled the cycle after
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= v;
        regWr     <= 1'h1;
        @(posedge sys_clk);
        regWr <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'h1;
        @(posedge sys_clk);
        regRd <= 1'h0;
        #1 d = regRdData;
    endtask
    task automatic stat(input logic [31:0] mask, input logic [31:0] want);
        rd(REG_STATUS);
        chk(d & mask, want);
    endtask
    task automatic put(input logic [15:0] c, input logic keep);
        wr(REG_DATA, {16'h0, c});
        if (keep) exp.push_back(c);
    endtask
    // Bounded waits; running out ends the run as a failure
    task automatic waitLoads(input int n);
        for (int i = 0; i < 4000 && dac.seen.size() < n; i++) @(posedge sys_clk);
        if (dac.seen.size() < n) begin
            chk(32'(dac.seen.size()), 32'(n));
            conclude();
        end
    endtask
    task automatic waitIdle();
        for (int i = 0; i < 200; i++) begin
            rd(REG_STATUS);
            if (d[ST_RUN] === 1'h0) break;
        end
        if (d[ST_RUN] !== 1'h0) begin
            chk(d, 32'h0);
            conclude();
        end
    endtask
    task automatic chkLoads(input int chn);
        chk(32'(dac.seen.size()), 32'(exp.size()));
        foreach (exp[i]) chk({12'h0, dac.seen[i]}, expLoad(i, chn));
        dac.seen.delete();
        exp.delete();
    endtask
    initial begin
        void'($urandom(32'hE639A4CA));
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        chk({16'h0, dacOut.code}, {16'h0, CODE_ZERO});
        stat(32'h1FF, 32'h0);
        rd(4'hF);
        chk(d, 32'h0);
        // FIFO: fill to the brim, top up and overflow while running
        wr(REG_CHCNT, 32'h4);
        wr(REG_CLKDIV, 32'h3F);
        wr(REG_SMPCNT, 32'h5);
        wr(REG_OUTCNT, 32'h4);
        wr(REG_CMD, 32'h8);
        for (int i = 0; i < 16; i++) put(i == 0 ? 16'h0000 : i == 1 ? 16'hFFFF : i == 2 ? 16'h8000 : 16'($urandom), 1'h1);
        rd(REG_FILL);
        chk(d, 32'h10);
        wr(REG_CMD, 32'h1);
        stat(32'h13, 32'h1);
        waitLoads(4);
        for (int i = 0; i < 5; i++) put(16'($urandom), i < 4);
        stat(32'h11, 32'h11);
        waitLoads(20);
        waitIdle();
        chkLoads(4);
        stat(32'hBF, 32'h94);
        wr(REG_CMD, 32'h4);
        stat(32'h18, 32'h0);
        // Ring with external rising start: two passes of four samples
        wr(REG_CMD, 32'h8);
        wr(REG_CTRL, 32'h5);
        wr(REG_CHCNT, 32'h2);
        wr(REG_SMPCNT, 32'h4);
        wr(REG_REPEAT, 32'h2);
        for (int i = 0; i < 4; i++) put(16'($urandom), 1'h1);
        wr(REG_CMD, 32'h1);
        repeat (40) @(posedge sys_clk);
        chk(32'(dac.seen.size()), 32'h0);
        stat(32'h3, 32'h3);
        ext_start_trigger_in <= 1'h1;
        waitLoads(4);
        repeat (60) @(posedge sys_clk);
        stat(32'h3, 32'h3);
        ext_start_trigger_in <= 1'h0;
        repeat (4) @(posedge sys_clk);
        ext_start_trigger_in <= 1'h1;
        waitLoads(8);
        waitIdle();
        for (int i = 0; i < 4; i++) exp.push_back(exp[i]);
        chkLoads(2);
        stat(32'h1E0, 32'h1E0);
        // FIFO: falling external stop after the count, then software stop
        wr(REG_CMD, 32'hC);
        wr(REG_CTRL, 32'h50);
        wr(REG_CHCNT, 32'h1);
        wr(REG_SMPCNT, 32'h2);
        wr(REG_XFERLVL, 32'h2);
        for (int i = 0; i < 4; i++) put(16'($urandom), 1'h1);
        ext_stop_trigger_in <= 1'h1;
        wr(REG_CMD, 32'h1);
        waitLoads(3);
        ext_stop_trigger_in <= 1'h0;
        waitIdle();
        chk(32'(dac.seen.size()), 32'h3);
        stat(32'h180, 32'h180);
        wr(REG_CTRL, 32'h20);
        wr(REG_CMD, 32'h1);
        repeat (300) @(posedge sys_clk);
        stat(32'h1, 32'h1);
        wr(REG_CMD, 32'h2);
        waitIdle();
        chkLoads(1);
        // External sample clock far faster than the load time
        wr(REG_CMD, 32'hC);
        wr(REG_CTRL, 32'h22);
        for (int i = 0; i < 8; i++) put(16'($urandom), 1'h0);
        wr(REG_CMD, 32'h1);
        repeat (20) begin
            repeat (2) @(posedge sys_clk);
            ext_sample_clock_in <= ~ext_sample_clock_in;
        end
        waitIdle();
        chk(32'(dac.seen.size()), 32'h0);
        stat(32'h9, 32'h8);
        conclude();
    end
endmodule // analog_output_sequencer_tb
